//--- src/hbs_pkg.sv
// Behaviour
// - sixteen-bit words clocked in on the serial clock
// - addressed register returned in the same frame
// - frame starts at select fall, acts at rise
// - serial output released when select rises
// - sample input on fall, shift output on rise
// - all accesses act on whole bytes
// - latched bits cleared only by host command
// - frames before enable delay are ignored
// - before first rise output is fault OR input
// - fault flag set by faults and power-on
// - clockless frame still shows the fault flag
// - status byte shifted out in first eight clocks
// - status byte holds the seven summary bits
// - fault flag is OR of fault bits and inverted not-reset-seen
// - not-reset-seen reads zero after power-on
// - frame error at bit seven, next frame
// - bad clock count is a protocol error
// - unused register address is a protocol error
// - address byte LSB zero is a protocol error
// - last-address token zero is a protocol error
// - clock high at select edges is an error
// - address byte then data byte, address bits 6:2
// - operation bit selects read or write/clear
package hbs_pkg;
    // ==========================================================
    // frame layout
    localparam int FRAME_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam logic [7:0] MIN_PULSES = 8'h10;
    localparam logic [4:0] TX_STOP = 5'h11;
    localparam logic [4:0] TX_BYTE = 5'h08;
    localparam logic [4:0] TX_FRAME = 5'h10;
    localparam int ONE_POS = 0;
    localparam int TOKEN_POS = 1;
    localparam int ADDR_LO = 2;
    localparam int ADDR_HI = 6;
    localparam int OP_POS = 7;
    // ==========================================================
    // register map
    localparam logic [4:0] STAT_ADDR = 5'h00;
    localparam logic [4:0] CFG_BASE = 5'h01;
    localparam logic [4:0] CFG_END = 5'h05;
    localparam int CFG_W = 32;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    // ==========================================================
    // global_fault_summary fields
    localparam int ST_NRS = 0;
    localparam int ST_TWARN = 1;
    localparam int ST_TSD = 2;
    localparam int ST_SHIGH = 3;
    localparam int ST_SLOW = 4;
    localparam int ST_LOAD = 5;
    localparam int ST_FERR = 7;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] STAT_CLEARED = 8'h01;
    // ==========================================================
    // timing
    localparam int MCLK_MHZ = 125;
    localparam int EN_DELAY_NS = 1000;
    localparam int EN_DELAY_CYC = (EN_DELAY_NS * MCLK_MHZ + 999) / 1000;
    localparam logic [7:0] EN_CYC = 8'(EN_DELAY_CYC);
endpackage : hbs_pkg

//--- src/hbs_spi_slave.sv
`timescale 1ns/10ps
module hbs_spi_slave (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic en,
    input wire logic open_load_in,
    input wire logic overcurrent_in,
    input wire logic supply_low_in,
    input wire logic supply_high_in,
    input wire logic thermal_shutdown_in,
    input wire logic thermal_warning_in,
    output logic sdo_o,
    output logic sdo_oe,
    output logic global_fault_o,
    output logic [7:0] status_o,
    output logic [31:0] cfg_o
);

    // ==========================================================
    // helpers
    function automatic logic addr_used(input logic [4:0] a);
        addr_used = (a == hbs_pkg::STAT_ADDR) ||
                    ((a >= hbs_pkg::CFG_BASE) && (a < hbs_pkg::CFG_END));
    endfunction : addr_used

    function automatic logic [7:0] rd_byte(input logic [4:0] a,
                                           input logic [7:0] st,
                                           input logic [31:0] cf);
        logic [4:0] off;
        off = a - hbs_pkg::CFG_BASE;
        rd_byte = 8'h00;
        if (a == hbs_pkg::STAT_ADDR) begin
            rd_byte = st;
        end else if (addr_used(a)) begin
            rd_byte = cf[{off[1:0], 3'b000} +: 8];
        end
    endfunction : rd_byte

    // ==========================================================
    // input synchronisers
    logic cs_s1_r, cs_s2_r, cs_d_r;
    logic sck_s1_r, sck_s2_r;
    logic en_s1_r, en_s2_r;
    logic [5:0] flt_s1_r, flt_s2_r;
    logic [5:0] flt_raw;

    assign flt_raw = {open_load_in, overcurrent_in, supply_low_in,
                      supply_high_in, thermal_shutdown_in, thermal_warning_in};

    // select, two stages plus edge history
    always_ff @(posedge mclk) begin
        if (rst) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_d_r <= 1'b1;
        end else begin
            cs_s1_r <= cs_n;
            cs_s2_r <= cs_s1_r;
            cs_d_r <= cs_s2_r;
        end
    end

    // serial clock level, for the polarity check
    always_ff @(posedge mclk) begin
        if (rst) begin
            sck_s1_r <= 1'b0;
            sck_s2_r <= 1'b0;
        end else begin
            sck_s1_r <= sclk;
            sck_s2_r <= sck_s1_r;
        end
    end

    // enable level
    always_ff @(posedge mclk) begin
        if (rst) begin
            en_s1_r <= 1'b0;
            en_s2_r <= 1'b0;
        end else begin
            en_s1_r <= en;
            en_s2_r <= en_s1_r;
        end
    end

    // fault levels
    always_ff @(posedge mclk) begin
        if (rst) begin
            flt_s1_r <= 6'h00;
            flt_s2_r <= 6'h00;
        end else begin
            flt_s1_r <= flt_raw;
            flt_s2_r <= flt_s1_r;
        end
    end

    // ==========================================================
    // link receive side, falling edges
    logic [15:0] rx_r, rx_nxt;
    logic [7:0] pcnt_r, pcnt_nxt;

    always_comb begin
        rx_nxt = {sdi, rx_r[15:1]};
        pcnt_nxt = pcnt_r + 8'h01;
    end

    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            rx_r <= 16'h0000;
            pcnt_r <= 8'h00;
        end else begin
            rx_r <= rx_nxt;
            pcnt_r <= pcnt_nxt;
        end
    end

    // ==========================================================
    // link transmit side, rising edges
    logic [4:0] tcnt_r, tcnt_nxt;
    logic [4:0] addr_r, addr_nxt;
    logic sdo_q_r, sdo_q_nxt;
    logic started_r, started_nxt;
    logic [7:0] stat_snap_r, stat_snap_nxt;
    logic [31:0] cfg_snap_r, cfg_snap_nxt;
    logic gef_r, gef_nxt;
    logic [4:0] tx_sel;
    logic [7:0] tx_byte;

    always_comb begin
        tcnt_nxt = tcnt_r;
        started_nxt = 1'b1;
        if (tcnt_r != hbs_pkg::TX_STOP) begin
            tcnt_nxt = tcnt_r + 5'h01;
        end
        addr_nxt = addr_r;
        tx_sel = addr_r;
        if (tcnt_r == hbs_pkg::TX_BYTE) begin
            // address byte has just landed in the upper half
            tx_sel = rx_r[hbs_pkg::BYTE_BITS + hbs_pkg::ADDR_HI :
                          hbs_pkg::BYTE_BITS + hbs_pkg::ADDR_LO];
            addr_nxt = tx_sel;
        end
        tx_byte = rd_byte(tx_sel, stat_snap_r, cfg_snap_r);
        sdo_q_nxt = 1'b0;
        if (tcnt_r < hbs_pkg::TX_BYTE) begin
            sdo_q_nxt = stat_snap_r[tcnt_r[2:0]];
        end else if (tcnt_r < hbs_pkg::TX_FRAME) begin
            sdo_q_nxt = tx_byte[tcnt_r[2:0]];
        end
    end

    always_ff @(posedge sclk or posedge cs_n or posedge rst) begin
        if (rst || cs_n) begin
            tcnt_r <= 5'h00;
            addr_r <= 5'h00;
            sdo_q_r <= 1'b0;
            started_r <= 1'b0;
        end else begin
            tcnt_r <= tcnt_nxt;
            addr_r <= addr_nxt;
            sdo_q_r <= sdo_q_nxt;
            started_r <= started_nxt;
        end
    end

    logic sdo_mux;

    // gef OR sdi until the first rising edge, also for clockless polls
    always_comb begin
        if (started_r) begin
            sdo_mux = sdo_q_r;
        end else begin
            sdo_mux = gef_r | sdi;
        end
    end

    assign sdo_o = sdo_mux;
    assign sdo_oe = ~cs_n;

    // ==========================================================
    // frame edges in the system clock domain
    logic fall;
    logic rise;
    logic cs_high;

    assign fall = cs_d_r & ~cs_s2_r;
    assign rise = ~cs_d_r & cs_s2_r;
    assign cs_high = cs_s2_r & cs_d_r;

    // ==========================================================
    // enable settle counter
    logic [7:0] en_cnt_r, en_cnt_nxt;
    logic en_ready;

    assign en_ready = (en_cnt_r == hbs_pkg::EN_CYC);

    always_comb begin
        en_cnt_nxt = en_cnt_r;
        if (!en_s2_r) begin
            en_cnt_nxt = 8'h00;
        end else if (!en_ready) begin
            en_cnt_nxt = en_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            en_cnt_r <= 8'h00;
        end else begin
            en_cnt_r <= en_cnt_nxt;
        end
    end

    // ==========================================================
    // frame start capture
    logic [7:0] start_cnt_r, start_cnt_nxt;
    logic pol_err_r, pol_err_nxt;
    logic frame_ok_r, frame_ok_nxt;

    always_comb begin
        start_cnt_nxt = start_cnt_r;
        pol_err_nxt = pol_err_r;
        frame_ok_nxt = frame_ok_r;
        if (fall) begin
            start_cnt_nxt = pcnt_r;
            pol_err_nxt = sck_s2_r;
            frame_ok_nxt = en_ready;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            start_cnt_r <= 8'h00;
            pol_err_r <= 1'b0;
            frame_ok_r <= 1'b0;
        end else begin
            start_cnt_r <= start_cnt_nxt;
            pol_err_r <= pol_err_nxt;
            frame_ok_r <= frame_ok_nxt;
        end
    end

    // ==========================================================
    // frame end checks
    logic [7:0] pulses;
    logic [4:0] dec_addr;
    logic [4:0] cfg_off;
    logic act;
    logic clocked;
    logic count_err;
    logic addr_err;
    logic pol_err;
    logic proto_err;
    logic do_write;

    always_comb begin
        pulses = pcnt_r - start_cnt_r;
        dec_addr = rx_r[hbs_pkg::ADDR_HI:hbs_pkg::ADDR_LO];
        cfg_off = dec_addr - hbs_pkg::CFG_BASE;
        act = rise && frame_ok_r;
        clocked = (pulses != 8'h00);
        count_err = 1'b0;
        if (clocked && (pulses[2:0] != 3'b000)) begin
            count_err = 1'b1;
        end
        if (clocked && (pulses < hbs_pkg::MIN_PULSES)) begin
            count_err = 1'b1;
        end
        addr_err = 1'b0;
        if (clocked) begin
            if (!addr_used(dec_addr)) begin
                addr_err = 1'b1;
            end
            if (!rx_r[hbs_pkg::ONE_POS]) begin
                addr_err = 1'b1;
            end
            if (!rx_r[hbs_pkg::TOKEN_POS]) begin
                addr_err = 1'b1;
            end
        end
        pol_err = pol_err_r || sck_s2_r;
        proto_err = act && (count_err || addr_err || pol_err);
        do_write = act && !proto_err && clocked && rx_r[hbs_pkg::OP_POS];
    end

    // ==========================================================
    // global fault summary
    logic [7:0] status_r, status_nxt;
    logic [7:0] set_bits;
    logic clear_stat;

    assign clear_stat = do_write && (dec_addr == hbs_pkg::STAT_ADDR);

    always_comb begin
        status_nxt = status_r;
        if (clear_stat) begin
            status_nxt = hbs_pkg::STAT_CLEARED;
        end
        // new events win over a clear in the same cycle
        set_bits = 8'h00;
        set_bits[hbs_pkg::ST_LOAD] = flt_s2_r[5] | flt_s2_r[4];
        set_bits[hbs_pkg::ST_SLOW] = flt_s2_r[3];
        set_bits[hbs_pkg::ST_SHIGH] = flt_s2_r[2];
        set_bits[hbs_pkg::ST_TSD] = flt_s2_r[1];
        set_bits[hbs_pkg::ST_TWARN] = flt_s2_r[0];
        set_bits[hbs_pkg::ST_FERR] = proto_err;
        status_nxt = status_nxt | set_bits;
        gef_nxt = status_nxt[hbs_pkg::ST_FERR] |
                  status_nxt[hbs_pkg::ST_LOAD] |
                  status_nxt[hbs_pkg::ST_SLOW] |
                  status_nxt[hbs_pkg::ST_SHIGH] |
                  status_nxt[hbs_pkg::ST_TSD] |
                  status_nxt[hbs_pkg::ST_TWARN] |
                  ~status_nxt[hbs_pkg::ST_NRS];
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            status_r <= hbs_pkg::STAT_RESET;
            gef_r <= 1'b1;
        end else begin
            status_r <= status_nxt;
            gef_r <= gef_nxt;
        end
    end

    // ==========================================================
    // configuration bytes
    logic [31:0] cfg_r, cfg_nxt;
    logic write_cfg;

    assign write_cfg = do_write && (dec_addr != hbs_pkg::STAT_ADDR);

    always_comb begin
        cfg_nxt = cfg_r;
        if (write_cfg) begin
            cfg_nxt[{cfg_off[1:0], 3'b000} +: 8] =
                rx_r[15:hbs_pkg::BYTE_BITS];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_r <= hbs_pkg::CFG_RESET;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // ==========================================================
    // response snapshots, held still while a frame is open
    always_comb begin
        stat_snap_nxt = stat_snap_r;
        cfg_snap_nxt = cfg_snap_r;
        if (cs_high) begin
            stat_snap_nxt = status_r;
            cfg_snap_nxt = cfg_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            stat_snap_r <= hbs_pkg::STAT_RESET;
            cfg_snap_r <= hbs_pkg::CFG_RESET;
        end else begin
            stat_snap_r <= stat_snap_nxt;
            cfg_snap_r <= cfg_snap_nxt;
        end
    end

    assign global_fault_o = gef_r;
    assign status_o = status_r;
    assign cfg_o = cfg_r;

endmodule : hbs_spi_slave

//--- sim/hbs_spi_slave_properties.sv
`timescale 1ns/10ps
// ====================
// port checker for the spi slave
module hbs_spi_slave_properties (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic thermal_shutdown_in,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    input wire logic global_fault_o,
    input wire logic [7:0] status_o,
    input wire logic [31:0] cfg_o
);
    logic [7:0] rises_r;
    logic [3:0] hi_r;
    logic sck_r;
    logic bad;
    // sclk rises per frame, cycles since select released
    always_ff @(posedge mclk) begin
        sck_r <= sclk;
        hi_r <= (rst || !cs_n) ? 4'h0 : hi_r + {3'h0, hi_r != 4'hF};
        if (rst || hi_r == 4'h8) rises_r <= 8'h00;
        else if (!cs_n && sclk && !sck_r) rises_r <= rises_r + 8'h01;
    end
    assign bad = rises_r != 8'h00 && (rises_r[2:0] != 3'h0 || rises_r < 8'h10);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    sequence s_bad_end;
        $rose(cs_n) && bad;
    endsequence
    sequence s_status_quiet;
        $stable(status_o) ##1 $stable(status_o);
    endsequence
    a_oe_follows_cs: assert property (sdo_oe == !cs_n)
        else $error("sdo_oe not tracking select");
    a_gef_is_or: assert property (s_status_quiet |->
        global_fault_o == ((|status_o[7:1]) | !status_o[0])) else $error("fault flag wrong");
    a_fault_latch: assert property (thermal_shutdown_in |->
        ##[1:5] status_o[hbs_pkg::ST_TSD]) else $error("fault not latched");
    a_no_self_clear: assert property (hi_r == 4'hF |->
        (status_o & $past(status_o)) == $past(status_o)) else $error("status cleared itself");
    a_cfg_after_rise: assert property (!$stable(cfg_o) |->
        hi_r inside {[4'h1:4'h6]}) else $error("config changed outside decode");
    a_sdo_before_rise: assert property (!cs_n && rises_r == 8'h00 && !sclk && !sck_r |->
        sdo_o == (global_fault_o | sdi)) else $error("early sdo wrong");
    a_frame_err_next: assert property (s_bad_end |->
        ##[1:6] status_o[hbs_pkg::ST_FERR]) else $error("frame error not flagged");
    a_reset_default: assert property ($fell(rst) |->
        status_o == 8'h00 && global_fault_o && cfg_o == 32'h0) else $error("bad reset state");
endmodule : hbs_spi_slave_properties
bind hbs_spi_slave hbs_spi_slave_properties i_hbs_spi_slave_properties (.mclk, .rst, .sclk,
    .cs_n, .sdi, .thermal_shutdown_in, .sdo_o, .sdo_oe, .global_fault_o, .status_o, .cfg_o);

//--- sim/hbs_host_model.sv
`timescale 1ns/10ps
// ====================
// spi master, sclk runs only inside frames
module hbs_host_model (
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo_o,
    input wire logic sdo_oe
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b1;
    end
    // pol set: clock held high across both select edges
    task automatic xfer(input logic [15:0] w, input int n, input bit pol,
                        output logic [15:0] r, output logic g);
        int k;
        sclk = pol;
        #20 cs_n = 1'b0;
        sdi = 1'b0;
        #20 g = sdo_o;
        sclk = 1'b0;
        #20 r = 16'h0000;
        for (k = 0; k < n; k++) begin
            sclk = 1'b1;
            sdi = w[k % 16];
            #32 sclk = 1'b0;
            if (k < 16 && sdo_oe) r[k] = sdo_o;
            #32;
        end
        #20 sclk = pol;
        #20 cs_n = 1'b1;
        sdi = ~sdi;
        #20 sclk = 1'b0;
        #80;
    endtask : xfer
endmodule : hbs_host_model

//--- sim/tb_spi_slave_fault_reporting.sv
`timescale 1ns/10ps
module tb_spi_slave_fault_reporting;
    logic mclk, rst, en, sclk, cs_n, sdi, sdo_o, sdo_oe, global_fault_o, g, op;
    logic [5:0] flt;
    logic [7:0] status_o, d;
    logic [31:0] cfg_o, cfg_e;
    logic [15:0] r, w;
    logic [4:0] a;
    integer seed = 80;
    integer n_mismatch = 0;
    integer checks = 0;
    integer cyc = 0;
    integer i;
    hbs_spi_slave i_hbs_spi_slave (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
        .sdi(sdi), .en(en), .open_load_in(flt[0]), .overcurrent_in(flt[1]),
        .supply_low_in(flt[2]), .supply_high_in(flt[3]), .thermal_shutdown_in(flt[4]),
        .thermal_warning_in(flt[5]), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .global_fault_o(global_fault_o), .status_o(status_o), .cfg_o(cfg_o));
    hbs_host_model i_hbs_host_model (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_o(sdo_o),
        .sdo_oe(sdo_oe));
    // ====================
    // helpers
    function automatic logic [15:0] cmd(input logic [4:0] ad, input logic o,
                                        input logic [7:0] dt);
        return {dt, o, ad, 2'b11};
    endfunction : cmd
    function automatic logic [31:0] fexp(input int k);
        return 32'h01 | (32'h1 << ((k < 2) ? 5 : 6 - k));
    endfunction : fexp
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic fr(input logic [15:0] wd, input int n, input bit pol = 1'b0);
        i_hbs_host_model.xfer(wd, n, pol, r, g);
    endtask : fr
    task automatic fwait(input int n);
        repeat (n) @(negedge mclk);
    endtask : fwait
    task automatic stop_test;
        if (n_mismatch == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    // ====================
    // main sequence
    initial begin
        rst = 1'b1;
        en = 1'b0;
        flt = 6'h00;
        fwait(4);
        rst = 1'b0;
        en = 1'b1;
        fwait(2);
        fr(cmd(5'h01, 1'b1, 8'hA5), 16);
        chk(cfg_o, 32'h0);
        chk(32'(status_o), 32'h00);
        chk(32'(g), 32'h1);
        fwait(hbs_pkg::EN_DELAY_CYC);
        fr(16'h0000, 0);
        chk(32'(g), 32'h1);
        fr(cmd(hbs_pkg::STAT_ADDR, 1'b1, 8'h00), 16);
        chk(32'(r), 32'h0000);
        chk(32'(status_o), 32'(hbs_pkg::STAT_CLEARED));
        fr(16'h0000, 0);
        chk(32'(g), 32'h0);
        cfg_e = 32'h0;
        for (i = 0; i < 12; i++) begin
            a = 5'h01 + 5'($random(seed) & 3);
            d = 8'($random(seed));
            op = 1'($random(seed));
            fr(cmd(a, op, d), 16);
            chk(32'(r), 32'({cfg_e[8 * (a - 1) +: 8], 8'h01}));
            if (op) cfg_e[8 * (a - 1) +: 8] = d;
            chk(cfg_o, cfg_e);
        end
        for (i = 0; i < 9; i++) begin
            w = (i == 2) ? 16'hFFFF : (i == 3) ? 16'h0000 :
                cmd((i == 4) ? 5'h05 : 5'h02, 1'b1, 8'h3C);
            w[0] = w[0] & (i != 0);
            w[1] = w[1] & (i != 1);
            fr(w, (i == 5) ? 8 : (i == 6) ? 12 : (i == 7) ? 17 : 16, i == 8);
            chk(cfg_o, cfg_e);
            fr(cmd(hbs_pkg::STAT_ADDR, 1'b1, 8'h00), 16);
            chk(32'(r[7:0]), 32'h81);
            chk(32'(status_o), 32'h01);
        end
        for (i = 0; i < 6; i++) begin
            flt = 6'h01 << i;
            fwait(10);
            flt = 6'h00;
            fwait(20);
            chk(32'(status_o), fexp(i));
            chk(32'(global_fault_o), 32'h1);
            fr(cmd(hbs_pkg::STAT_ADDR, 1'b1, 8'h00), 16);
            chk(32'(r[7:0]), fexp(i));
            chk(32'(status_o), 32'h01);
            fwait(1);
        end
        stop_test();
    end
endmodule : tb_spi_slave_fault_reporting
